/* hw/gport_ctrl.sv */
// Graphics port command and control registers with operation gating and rate selection
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module gport_ctrl
	import gport_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Avalon-MM register slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Request pins from the graphics master
	input wire logic pipe_req_pin,
	input wire logic sba_req_pin,
	input wire logic sync_pin,
	// Operation progress
	output logic op_busy,
	output logic op_from_sba,
	output logic op_done,
	output logic sba_issue,
	output logic sync_ack,
	// Transfer rate and write protocol
	output logic [2:0] ad_rate,
	output logic [2:0] sba_rate,
	output logic write_fast,
	output logic [2:0] fw_rate,
	// Translation buffer access
	input wire logic xl_fill_req,
	input wire logic [XB_TAG_W-1:0] xl_fill_tag,
	input wire logic [XB_FRAME_W-1:0] xl_fill_frame,
	input wire logic xl_lookup_req,
	input wire logic [XB_TAG_W-1:0] xl_lookup_tag,
	output logic xl_done,
	output logic xl_hit,
	output logic [XB_FRAME_W-1:0] xl_frame
);

	typedef struct packed {
		bus_state_t bus;
		logic [31:0] rdata;
		logic sba_en;
		logic port_en;
		logic fw_en;
		logic [2:0] rate;
		logic xb_en;
		logic ovr;
		logic [2:0] seen;
		op_state_t op;
		logic [7:0] cnt;
		logic op_sba;
		logic busy;
		logic done;
		logic sba_issue;
		logic sync_ack;
		logic [7:0] pipe_count;
		logic [7:0] sba_count;
		logic [7:0] ign_count;
		logic [2:0] ad_rate;
		logic [2:0] sba_rate;
		logic fast;
		logic [2:0] fw_rate;
	} ctl_state_t;

	ctl_state_t cur_ff;
	ctl_state_t nxt_cur;
	logic [2:0] pin_vec;
	logic [2:0] lvl;

	assign pin_vec = {sync_pin, sba_req_pin, pipe_req_pin};

	// One synchroniser per request pin
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			pin_sync u_sync (
				.mclk(mclk),
				.srst(srst),
				.pin(pin_vec[gi]),
				.level(lvl[gi])
			);
		end
	endgenerate

	xlate_buffer u_xlate (
		.mclk(mclk),
		.srst(srst),
		.enable(cur_ff.xb_en),
		.fill_req(xl_fill_req),
		.fill_tag(xl_fill_tag),
		.fill_frame(xl_fill_frame),
		.lookup_req(xl_lookup_req),
		.lookup_tag(xl_lookup_tag),
		.lookup_done(xl_done),
		.lookup_hit(xl_hit),
		.lookup_frame(xl_frame)
	);

	// Merge write data into a register under byte enables and writable mask
	function automatic logic [31:0] merge_write(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be,
		input logic [31:0] wmask
	);
		logic [31:0] lanes;
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return ((old & ~lanes) | (wd & lanes)) & wmask;
	endfunction : merge_write

	function automatic logic [31:0] cmd_word(input ctl_state_t s);
		logic [31:0] w;
		w = CMD_RESET;
		w[CMD_SBA_EN_BIT] = s.sba_en;
		w[CMD_PORT_EN_BIT] = s.port_en;
		w[CMD_FW_EN_BIT] = s.fw_en;
		w[CMD_RATE_LSB +: 3] = s.rate;
		return w;
	endfunction : cmd_word

	function automatic logic [31:0] ctl_word(input ctl_state_t s);
		logic [31:0] w;
		w = CTL_RESET;
		w[CTL_XB_EN_BIT] = s.xb_en;
		w[CTL_OVR_BIT] = s.ovr;
		return w;
	endfunction : ctl_word

	function automatic logic [31:0] sts_word(input logic ovr);
		logic [31:0] w;
		w = '0;
		w[STS_QUEUE_LSB +: 8] = STS_QUEUE;
		w[STS_SBA_BIT] = 1'b1;
		w[STS_FW_BIT] = 1'b1;
		w[2:0] = ovr ? RATE_ONE : RATE_ALL;
		return w;
	endfunction : sts_word

	function automatic logic [31:0] act_word(input ctl_state_t s);
		logic [31:0] w;
		w = '0;
		w[7:0] = s.pipe_count;
		w[ACT_SBA_LSB +: 8] = s.sba_count;
		w[ACT_IGN_LSB +: 8] = s.ign_count;
		w[ACT_BUSY_BIT] = s.busy;
		return w;
	endfunction : act_word

	// Register selected by a bus address
	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_STATUS = 3'h1,
		SEL_COMMAND = 3'h2,
		SEL_CONTROL = 3'h3,
		SEL_ACTIVITY = 3'h4
	} reg_sel_t;

	// Address decode shared by reads and writes
	function automatic reg_sel_t reg_decode(input logic [7:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		if (a == OFS_STATUS) begin
			s = SEL_STATUS;
		end else if (a == OFS_COMMAND) begin
			s = SEL_COMMAND;
		end else if (a == OFS_CONTROL) begin
			s = SEL_CONTROL;
		end else if (a == OFS_ACTIVITY) begin
			s = SEL_ACTIVITY;
		end
		return s;
	endfunction : reg_decode

	// Delivery beats of a sideband command at the selected rate
	function automatic logic [7:0] sba_reload(input rate_t r);
		logic [7:0] n;
		n = SBA_BEATS_FAST - 8'h01;
		if (r == RATE_1X) begin
			n = SBA_BEATS_1X - 8'h01;
		end
		return n;
	endfunction : sba_reload

	always_comb begin
		logic [2:0] rise;
		logic [31:0] wcmd;
		logic [31:0] wctl;
		rate_t dec;
		reg_sel_t sel;
		logic [7:0] ign_inc;
		rise = lvl & ~cur_ff.seen;
		sel = reg_decode(avs_address);
		ign_inc = 8'h00;
		wcmd = '0;
		wctl = '0;
		dec = rate_decode(cur_ff.rate);
		nxt_cur = cur_ff;
		nxt_cur.seen = lvl;
		nxt_cur.done = 1'b0;
		nxt_cur.sba_issue = 1'b0;
		nxt_cur.sync_ack = 1'b0;

		// Register slave: one wait cycle, then answer for one cycle
		case (cur_ff.bus)
			BUS_WAIT: begin
				if (avs_read || avs_write) begin
					nxt_cur.bus = BUS_ANSWER;
				end
				nxt_cur.rdata = '0;
				if (avs_read) begin
					if (sel == SEL_STATUS) begin
						nxt_cur.rdata = sts_word(cur_ff.ovr);
					end else if (sel == SEL_COMMAND) begin
						nxt_cur.rdata = cmd_word(cur_ff);
					end else if (sel == SEL_CONTROL) begin
						nxt_cur.rdata = ctl_word(cur_ff);
					end else if (sel == SEL_ACTIVITY) begin
						nxt_cur.rdata = act_word(cur_ff);
					end
				end
			end
			BUS_ANSWER: begin
				// Read data stand for the answer cycle only
				nxt_cur.bus = BUS_WAIT;
				nxt_cur.rdata = '0;
				if (avs_write) begin
					if (sel == SEL_COMMAND) begin
						wcmd = merge_write(cmd_word(cur_ff), avs_writedata,
							avs_byteenable, CMD_WMASK);
						nxt_cur.sba_en = wcmd[CMD_SBA_EN_BIT];
						nxt_cur.port_en = wcmd[CMD_PORT_EN_BIT];
						nxt_cur.fw_en = wcmd[CMD_FW_EN_BIT];
						nxt_cur.rate = wcmd[CMD_RATE_LSB +: 3];
					end else if (sel == SEL_CONTROL) begin
						wctl = merge_write(ctl_word(cur_ff), avs_writedata,
							avs_byteenable, CTL_WMASK);
						nxt_cur.xb_en = wctl[CTL_XB_EN_BIT];
						nxt_cur.ovr = wctl[CTL_OVR_BIT];
					end
				end
			end
			default: begin
				nxt_cur.bus = BUS_WAIT;
			end
		endcase

		// Sync cycles are answered only while the port is enabled
		if (rise[2]) begin
			if (cur_ff.port_en) begin
				nxt_cur.sync_ack = 1'b1;
			end else begin
				ign_inc = ign_inc + 8'h01;
			end
		end

		// Port operation sequencing
		case (cur_ff.op)
			OP_IDLE: begin
				// Pipe request wins when both rise together
				if (rise[0] && cur_ff.port_en) begin
					nxt_cur.op = OP_SERVE;
					nxt_cur.cnt = OP_SERVICE_CYCLES - 8'h01;
					nxt_cur.busy = 1'b1;
					nxt_cur.op_sba = 1'b0;
					nxt_cur.pipe_count = cur_ff.pipe_count + 8'h01;
				end else if (rise[1] && cur_ff.port_en && cur_ff.sba_en) begin
					nxt_cur.op = OP_DELIVER;
					nxt_cur.cnt = sba_reload(dec);
					nxt_cur.busy = 1'b1;
					nxt_cur.op_sba = 1'b1;
					nxt_cur.sba_count = cur_ff.sba_count + 8'h01;
				end else if (rise[0] || rise[1]) begin
					ign_inc = ign_inc + 8'h01;
				end
			end
			OP_DELIVER: begin
				// Enable is no longer looked at once delivery has begun
				if (cur_ff.cnt == 8'h00) begin
					nxt_cur.sba_issue = 1'b1;
					nxt_cur.op = OP_SERVE;
					nxt_cur.cnt = OP_SERVICE_CYCLES - 8'h01;
				end else begin
					nxt_cur.cnt = cur_ff.cnt - 8'h01;
				end
			end
			OP_SERVE: begin
				if (cur_ff.cnt == 8'h00) begin
					nxt_cur.op = OP_DONE;
					nxt_cur.done = 1'b1;
				end else begin
					nxt_cur.cnt = cur_ff.cnt - 8'h01;
				end
			end
			OP_DONE: begin
				nxt_cur.op = OP_IDLE;
				nxt_cur.busy = 1'b0;
				nxt_cur.op_sba = 1'b0;
			end
			default: begin
				nxt_cur.op = OP_IDLE;
				nxt_cur.busy = 1'b0;
			end
		endcase

		// A sync and an op request may both be ignored in one cycle
		nxt_cur.ign_count = cur_ff.ign_count + ign_inc;

		// Rate applies to both buses and to fast writes
		nxt_cur.ad_rate = rate_code(dec);
		nxt_cur.sba_rate = rate_code(dec);
		nxt_cur.fast = cur_ff.fw_en && (dec != RATE_1X);
		nxt_cur.fw_rate = nxt_cur.fast ? rate_code(dec) : 3'h0;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cur_ff <= '0;
			cur_ff.bus <= BUS_WAIT;
			// AD and sideband rate outputs idle at 1X; fw_rate resets to 0
			cur_ff.ad_rate <= RATE_ONE;
			cur_ff.sba_rate <= RATE_ONE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign avs_readdata = cur_ff.rdata;
	assign avs_waitrequest = cur_ff.bus;
	assign op_busy = cur_ff.busy;
	assign op_from_sba = cur_ff.op_sba;
	assign op_done = cur_ff.done;
	assign sba_issue = cur_ff.sba_issue;
	assign sync_ack = cur_ff.sync_ack;
	assign ad_rate = cur_ff.ad_rate;
	assign sba_rate = cur_ff.sba_rate;
	assign write_fast = cur_ff.fast;
	assign fw_rate = cur_ff.fw_rate;

endmodule : gport_ctrl

/* hw/gport_pkg.sv */
// Constants, types and rate decoding shared by the graphics port control block
package gport_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'hA4;
	localparam logic [7:0] OFS_COMMAND = 8'hA8;
	localparam logic [7:0] OFS_CONTROL = 8'hB0;
	localparam logic [7:0] OFS_ACTIVITY = 8'hC0;

	// Field positions
	localparam int CMD_SBA_EN_BIT = 9;
	localparam int CMD_PORT_EN_BIT = 8;
	localparam int CMD_FW_EN_BIT = 4;
	localparam int CMD_RATE_LSB = 0;
	localparam int CTL_XB_EN_BIT = 7;
	localparam int CTL_OVR_BIT = 0;
	localparam int STS_QUEUE_LSB = 24;
	localparam int STS_SBA_BIT = 9;
	localparam int STS_FW_BIT = 4;
	localparam int ACT_SBA_LSB = 8;
	localparam int ACT_IGN_LSB = 16;
	localparam int ACT_BUSY_BIT = 24;

	// Reset values and writable masks
	localparam logic [31:0] CMD_RESET = 32'h0000_0000;
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	localparam logic [31:0] CMD_WMASK = 32'h0000_0317;
	localparam logic [31:0] CTL_WMASK = 32'h0000_0081;

	// Status contents
	localparam logic [7:0] STS_QUEUE = 8'h1F;
	localparam logic [2:0] RATE_ALL = 3'h7;
	localparam logic [2:0] RATE_ONE = 3'h1;
	localparam logic [2:0] RATE_TWO = 3'h2;
	localparam logic [2:0] RATE_FOUR = 3'h4;

	// Cycle counts
	localparam logic [7:0] OP_SERVICE_CYCLES = 8'h08;
	localparam logic [7:0] SBA_BEATS_1X = 8'h02;
	localparam logic [7:0] SBA_BEATS_FAST = 8'h01;

	// Translation buffer geometry
	localparam int XB_ENTRIES = 8;
	localparam int XB_IDX_W = 3;
	localparam int XB_TAG_W = 20;
	localparam int XB_FRAME_W = 20;

	typedef enum logic [1:0] {
		RATE_1X = 2'b00,
		RATE_2X = 2'b01,
		RATE_4X = 2'b11
	} rate_t;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_DELIVER = 2'b01,
		OP_SERVE = 2'b11,
		OP_DONE = 2'b10
	} op_state_t;

	// Waitrequest is the state bit itself
	typedef enum logic {
		BUS_ANSWER = 1'b0,
		BUS_WAIT = 1'b1
	} bus_state_t;

	// Illegal codes fall back to the slowest rate
	function automatic rate_t rate_decode(input logic [2:0] code);
		rate_t r;
		r = RATE_1X;
		if (code == RATE_TWO) begin
			r = RATE_2X;
		end else if (code == RATE_FOUR) begin
			r = RATE_4X;
		end
		return r;
	endfunction : rate_decode

	function automatic logic [2:0] rate_code(input rate_t r);
		logic [2:0] c;
		c = RATE_ONE;
		if (r == RATE_2X) begin
			c = RATE_TWO;
		end else if (r == RATE_4X) begin
			c = RATE_FOUR;
		end
		return c;
	endfunction : rate_code

endpackage : gport_pkg

/* hw/pin_sync.sv */
// Three-stage synchroniser that accepts a new level once stages two and three agree
`timescale 1ns/1ns
module pin_sync
	import gport_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Asynchronous pin and its settled level
	input wire logic pin,
	output logic level
);

	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic level;
	} sync_state_t;

	sync_state_t cur_ff;
	sync_state_t nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.f1 = pin;
		nxt_cur.f2 = cur_ff.f1;
		nxt_cur.f3 = cur_ff.f2;
		if (cur_ff.f2 == cur_ff.f3) begin
			nxt_cur.level = cur_ff.f3;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign level = cur_ff.level;

endmodule : pin_sync

/* hw/xlate_buffer.sv */
// Direct-mapped graphics translation buffer with registered lookup result
`timescale 1ns/1ns
module xlate_buffer
	import gport_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Control
	input wire logic enable,
	// Fill
	input wire logic fill_req,
	input wire logic [XB_TAG_W-1:0] fill_tag,
	input wire logic [XB_FRAME_W-1:0] fill_frame,
	// Lookup
	input wire logic lookup_req,
	input wire logic [XB_TAG_W-1:0] lookup_tag,
	output logic lookup_done,
	output logic lookup_hit,
	output logic [XB_FRAME_W-1:0] lookup_frame
);

	typedef struct packed {
		logic [XB_ENTRIES-1:0] valid;
		logic [XB_ENTRIES-1:0][XB_TAG_W-1:0] tag;
		logic [XB_ENTRIES-1:0][XB_FRAME_W-1:0] frame;
		logic done;
		logic hit;
		logic [XB_FRAME_W-1:0] frame_out;
	} xb_state_t;

	xb_state_t cur_ff;
	xb_state_t nxt_cur;

	always_comb begin
		logic [XB_IDX_W-1:0] fidx;
		logic [XB_IDX_W-1:0] lidx;
		fidx = fill_tag[XB_IDX_W-1:0];
		lidx = lookup_tag[XB_IDX_W-1:0];
		nxt_cur = cur_ff;
		nxt_cur.done = lookup_req;
		nxt_cur.hit = 1'b0;
		nxt_cur.frame_out = '0;
		if (!enable) begin
			nxt_cur.valid = '0;
		end else begin
			if (lookup_req && cur_ff.valid[lidx] && cur_ff.tag[lidx] == lookup_tag) begin
				nxt_cur.hit = 1'b1;
				nxt_cur.frame_out = cur_ff.frame[lidx];
			end
			if (fill_req) begin
				nxt_cur.valid[fidx] = 1'b1;
				nxt_cur.tag[fidx] = fill_tag;
				nxt_cur.frame[fidx] = fill_frame;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign lookup_done = cur_ff.done;
	assign lookup_hit = cur_ff.hit;
	assign lookup_frame = cur_ff.frame_out;

endmodule : xlate_buffer

/* testbench/gfx_master_model.sv */
// Graphics master model raising request pins on command
`timescale 1ns/1ns
module gfx_master_model (
	// Clock
	input wire logic mclk,
	// Commands from the bench
	input wire logic [2:0] fire,
	// Request pins
	output logic pipe_req_pin,
	output logic sba_req_pin,
	output logic sync_pin
);
	logic [2:0] pin_ff = 3'h0;
	logic [3:0] hold_ff = 4'h0;
	assign {sync_pin, sba_req_pin, pipe_req_pin} = pin_ff;
	// Each request is a rising edge held long enough to be synchronised
	always @(posedge mclk) begin
		if (fire != 3'h0) begin
			pin_ff <= fire;
			hold_ff <= 4'hA;
		end else if (hold_ff != 4'h0) begin
			hold_ff <= hold_ff - 4'h1;
			if (hold_ff == 4'h1) pin_ff <= 3'h0;
		end
	end
endmodule : gfx_master_model

/* testbench/gport_ctrl_sva.sv */
// Concurrent checks on the graphics port control block
`timescale 1ns/1ns
module gport_ctrl_sva
	import gport_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Port side
	input wire logic op_busy,
	input wire logic op_from_sba,
	input wire logic op_done,
	input wire logic sba_issue,
	input wire logic sync_ack,
	input wire logic [2:0] ad_rate,
	input wire logic [2:0] sba_rate,
	input wire logic write_fast,
	input wire logic [2:0] fw_rate,
	input wire logic xl_lookup_req,
	input wire logic xl_done,
	input wire logic xl_hit
);
	logic [31:0] cmd_ff, ctl_ff, nxt_cmd, nxt_ctl, lanes;
	logic [3:0] off_ff;
	logic [2:0] er;
	logic fe, wr;
	assign wr = avs_write && !avs_waitrequest;
	assign lanes = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign nxt_cmd = (cmd_ff & ~(lanes & CMD_WMASK)) | (avs_writedata & lanes & CMD_WMASK);
	assign nxt_ctl = (ctl_ff & ~(lanes & CTL_WMASK)) | (avs_writedata & lanes & CTL_WMASK);
	assign er = $onehot(cmd_ff[2:0]) ? cmd_ff[2:0] : RATE_ONE;
	assign fe = cmd_ff[CMD_FW_EN_BIT] && er != RATE_ONE;
	// Shadow registers and cycles spent with the port disabled
	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_ff <= CMD_RESET;
			ctl_ff <= CTL_RESET;
			off_ff <= 4'h0;
		end else begin
			if (wr && avs_address == OFS_COMMAND) cmd_ff <= nxt_cmd;
			if (wr && avs_address == OFS_CONTROL) ctl_ff <= nxt_ctl;
			off_ff <= cmd_ff[CMD_PORT_EN_BIT] ? 4'h0 : off_ff + {3'h0, off_ff != 4'h8};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_take;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_sba_start;
		$rose(op_busy) && op_from_sba;
	endsequence
	a_bus_answer: assert property (s_take |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");
	a_cmd_readback: assert property (avs_read && !avs_waitrequest && avs_address == OFS_COMMAND |-> avs_readdata == cmd_ff)
		else $error("command read wrong");
	a_ctl_readback: assert property (avs_read && !avs_waitrequest && avs_address == OFS_CONTROL |-> avs_readdata == ctl_ff)
		else $error("control read wrong");
	a_status_rate: assert property (avs_read && !avs_waitrequest && avs_address == OFS_STATUS |-> avs_readdata[2:0] == (ctl_ff[0] ? RATE_ONE : RATE_ALL))
		else $error("status rate wrong");
	a_rate_follow: assert property (ad_rate == $past(er) && sba_rate == ad_rate)
		else $error("rate outputs wrong");
	a_fast_write: assert property (write_fast == $past(fe) && fw_rate == (write_fast ? ad_rate : 3'h0))
		else $error("write protocol wrong");
	a_disabled_quiet: assert property (off_ff == 4'h8 |-> !sync_ack && !$rose(op_busy))
		else $error("activity while disabled");
	a_sba_gate: assert property (s_sba_start |-> $past(cmd_ff[9]) && $past(cmd_ff[8]))
		else $error("sideband op accepted while gated");
	a_pipe_service: assert property ($rose(op_busy) && !op_from_sba |-> (!op_done)[*8] ##1 op_done ##1 !op_busy)
		else $error("pipe op service wrong");
	a_sba_issue: assert property (s_sba_start |-> ##[1:3] sba_issue ##[7:9] op_done)
		else $error("sideband op not issued");
	a_xlate_flush: assert property (xl_hit |-> $past(ctl_ff[7]))
		else $error("hit while buffer disabled");
	a_xlate_answer: assert property (xl_lookup_req |=> xl_done)
		else $error("lookup unanswered");
endmodule : gport_ctrl_sva
bind gport_ctrl gport_ctrl_sva u_sva (.*);

/* testbench/gport_ctrl_tb.sv */
// Self-checking bench for the graphics port control registers
`timescale 1ns/1ns
module gport_ctrl_tb
	import gport_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q, w;
	logic [3:0] avs_byteenable = 4'hF;
	logic pipe_req_pin, sba_req_pin, sync_pin, op_busy, op_from_sba, op_done, sba_issue;
	logic sync_ack, write_fast, xl_done, xl_hit, busy_q = 1'b0;
	logic [2:0] ad_rate, sba_rate, fw_rate, fire = 3'h0;
	logic xl_fill_req = 1'b0, xl_lookup_req = 1'b0;
	logic [XB_TAG_W-1:0] xl_fill_tag = '0, xl_lookup_tag = '0;
	logic [XB_FRAME_W-1:0] xl_fill_frame = '0, xl_frame;
	int n_mismatch = 0, samples_checked = 0, n_done = 0, n_iss = 0, n_sync = 0, n_busy = 0;
	always #2 mclk = ~mclk;
	gport_ctrl dut (.*);
	gfx_master_model master (.*);
	always @(posedge mclk) begin
		busy_q <= op_busy;
		if (op_done === 1'b1) n_done <= n_done + 1;
		if (sba_issue === 1'b1) n_iss <= n_iss + 1;
		if (sync_ack === 1'b1) n_sync <= n_sync + 1;
		if (op_busy === 1'b1 && busy_q === 1'b0) n_busy <= n_busy + 1;
	end
	function automatic logic exp_fast(input logic [31:0] c);
		return c[4] && c[2:0] != RATE_ONE;
	endfunction : exp_fast
	task report_and_stop;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task pulse(input logic [2:0] f);
		@(posedge mclk);
		fire <= f;
		@(posedge mclk);
		fire <= 3'h0;
		repeat (40) @(posedge mclk);
	endtask : pulse
	task look(input logic [19:0] t, input logic hit, input logic [19:0] fr);
		@(posedge mclk);
		xl_lookup_req <= 1'b1;
		xl_lookup_tag <= t;
		@(posedge mclk);
		xl_lookup_req <= 1'b0;
		@(posedge mclk);
		chk("lookup done", 32'(xl_done), 32'h1);
		chk("lookup hit", 32'(xl_hit), 32'(hit));
		if (hit) chk("lookup frame", 32'(xl_frame), 32'(fr));
	endtask : look
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'hC5DBFC4F));
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		bus(1'b0, OFS_COMMAND, 32'h0, 4'hF);
		chk("command reset", q, CMD_RESET);
		bus(1'b0, OFS_CONTROL, 32'h0, 4'hF);
		chk("control reset", q, CTL_RESET);
		bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk("status", q, 32'h1F000217);
		bus(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, 8'h10, 32'h0, 4'hF);
		chk("unmapped", q, 32'h0);
		for (int i = 0; i < 12; i++) begin
			w = $urandom;
			w[2:0] = RATE_ONE << (i % 3);
			bus(1'b1, OFS_COMMAND, w, 4'hF);
			bus(1'b0, OFS_COMMAND, 32'h0, 4'hF);
			chk("command", q, w & CMD_WMASK);
			chk("ad rate", 32'(ad_rate), 32'(w[2:0]));
			chk("sba rate", 32'(sba_rate), 32'(w[2:0]));
			chk("fast write", 32'(write_fast), 32'(exp_fast(w)));
			chk("fw rate", 32'(fw_rate), exp_fast(w) ? 32'(w[2:0]) : 32'h0);
		end
		bus(1'b1, OFS_COMMAND, 32'h0, 4'h2);
		bus(1'b0, OFS_COMMAND, 32'h0, 4'hF);
		chk("lane write", q, w & CMD_WMASK & 32'hFFFF00FF);
		bus(1'b1, OFS_CONTROL, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, OFS_CONTROL, 32'h0, 4'hF);
		chk("control", q, CTL_WMASK);
		bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk("status override", q, 32'h1F000211);
		@(posedge mclk);
		xl_fill_req <= 1'b1;
		xl_fill_tag <= 20'h12345;
		xl_fill_frame <= 20'hABCDE;
		@(posedge mclk);
		xl_fill_req <= 1'b0;
		look(20'h12345, 1'b1, 20'hABCDE);
		bus(1'b1, OFS_CONTROL, 32'h0, 4'hF);
		bus(1'b1, OFS_CONTROL, 32'h80, 4'hF);
		look(20'h12345, 1'b0, 20'h0);
		bus(1'b1, OFS_COMMAND, 32'h104, 4'hF);
		pulse(3'h1);
		chk("pipe op", n_done, 1);
		pulse(3'h2);
		chk("sideband gated", n_busy, 1);
		pulse(3'h4);
		chk("sync", n_sync, 1);
		bus(1'b1, OFS_COMMAND, 32'h301, 4'hF);
		fire <= 3'h2;
		@(posedge mclk);
		fire <= 3'h0;
		// Enable falls on the edge between acceptance and issue in 1X
		repeat (3) @(posedge mclk);
		bus(1'b1, OFS_COMMAND, 32'h1, 4'hF);
		repeat (40) @(posedge mclk);
		chk("sideband issue", n_iss, 1);
		chk("op completes", n_done, 2);
		pulse(3'h1);
		pulse(3'h4);
		chk("disabled op", n_busy, 2);
		chk("disabled sync", n_sync, 1);
		bus(1'b0, OFS_ACTIVITY, 32'h0, 4'hF);
		chk("activity", q, 32'h00030101);
		report_and_stop();
	end
endmodule : gport_ctrl_tb
